/* File: design/tarw_chan_mem.sv */
// Per-channel store of the last written analog settings
`timescale 1ns/10ps
`include "tarw_defs.svh"

module tarw_chan_mem
  import tarw_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  input  wire logic                      ce,
  input  wire logic                      wr_en,
  input  wire logic [`TARW_CHAN_AW-1:0]  wr_addr,
  input  wire tarw_setting_s             wr_data,
  input  wire logic [`TARW_CHAN_AW-1:0]  rd_addr,
  output tarw_setting_s                  rd_data
);

  // ============================================================
  // Storage
  tarw_setting_s mem_r [`TARW_CHAN_COUNT];  // Settings per channel
  tarw_setting_s rd_r;                      // Registered read word
  tarw_setting_s rd_nxt;                    // Next read word

  // Read word follows the address one cycle later
  always_comb begin
    rd_nxt = mem_r[rd_addr];
  end

  // Memory has no reset; the controller clears it during calibration
  always_ff @(posedge core_clk) begin
    if (ce && wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Read register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_r <= `TARW_SET_RST;
    end else if (ce) begin
      rd_r <= rd_nxt;
    end
  end

  assign rd_data = rd_r;

endmodule : tarw_chan_mem

/* File: design/tarw_defs.svh */
// Constants of the analog reconfiguration write block
// How it works
// [R1] Channel address only matters with several channels
// [R2] Swing setting 3 bits, pre-emphasis 5 bits
// [R3] DC gain 2 bits, equalizer control 4 bits
// [R4] User sets all enabled settings before writing
// [R5] User sets target channel address before strobe
// [R6] Direction code 2'b10 writes transmit settings only
// [R7] User checks busy low before new write
// [R8] User pulses write strobe for one cycle
// [R9] Busy high while transferring, low when done
// [R10] User never requests read and write together
// [R11] All-channel method needs every setting each write
// [R12] Direction allows duplex, transmit only, receive only
// [R13] Per-channel addressing preferred for time-critical use
// [R14] Busy moves only for calibration or requests
// [R15] Inputs captured on edge with strobe high
// [R16] Strobe while busy is ignored
`ifndef TARW_DEFS_SVH
`define TARW_DEFS_SVH

// ============================================================
// Field widths
`define TARW_VOD_W       3
`define TARW_PREEMP_W    5
`define TARW_DCGAIN_W    2
`define TARW_EQCTRL_W    4
`define TARW_DATA_W      5
`define TARW_SET_W       14

// ============================================================
// Channel space
`define TARW_CHAN_COUNT  4
`define TARW_CHAN_AW     2

// ============================================================
// Power-up offset cancellation time
`define TARW_CLK_PERIOD_NS 10
`define TARW_OFFCAL_NS     1000
`define TARW_OFFCAL_CYCLES \
  ((`TARW_OFFCAL_NS + `TARW_CLK_PERIOD_NS - 1) / `TARW_CLK_PERIOD_NS)
`define TARW_CNT_W         8

// ============================================================
// Reset values
`define TARW_SET_RST     14'h0000

`endif

/* File: design/tarw_pkg.sv */
// Types shared by the analog reconfiguration write block
`include "tarw_defs.svh"

package tarw_pkg;

  // ============================================================
  // Analog front end settings of one channel
  typedef struct packed {
    logic [`TARW_VOD_W-1:0]    vod;     // Output swing
    logic [`TARW_PREEMP_W-1:0] preemp;  // Pre-emphasis
    logic [`TARW_DCGAIN_W-1:0] dcgain;  // Equalizer DC gain
    logic [`TARW_EQCTRL_W-1:0] eqctrl;  // Equalizer control
  } tarw_setting_s;

  // Direction select codes; 2'b00 is handled as duplex
  typedef enum logic [1:0] {
    TARW_DIR_ZERO   = 2'b00,
    TARW_DIR_RX     = 2'b01,
    TARW_DIR_TX     = 2'b10,
    TARW_DIR_DUPLEX = 2'b11
  } tarw_dir_e;

  // Field pushed to the channel, transmit fields first
  typedef enum logic [1:0] {
    TARW_FLD_VOD    = 2'b00,
    TARW_FLD_PREEMP = 2'b01,
    TARW_FLD_DCGAIN = 2'b10,
    TARW_FLD_EQCTRL = 2'b11
  } tarw_field_e;

  // Controller states
  typedef enum logic [1:0] {
    TARW_ST_CAL    = 2'b00,
    TARW_ST_IDLE   = 2'b01,
    TARW_ST_PUSH   = 2'b10,
    TARW_ST_COMMIT = 2'b11
  } tarw_state_e;

endpackage : tarw_pkg

/* File: design/tarw_write_ctrl.sv */
// Write controller pushing analog settings into one channel
`timescale 1ns/10ps
`include "tarw_defs.svh"

module tarw_write_ctrl
  import tarw_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  input  wire logic                      ce,
  input  wire tarw_setting_s             setting_in,
  input  wire logic [`TARW_CHAN_AW-1:0]  chan_addr,
  input  wire logic [1:0]                dir_sel,
  input  wire logic                      write_strobe,
  output logic                           busy,
  output tarw_setting_s                  setting_out,
  output logic                           afe_valid,
  input  wire logic                      afe_ready,
  output logic [`TARW_CHAN_AW-1:0]       afe_chan,
  output logic [1:0]                     afe_field,
  output logic [`TARW_DATA_W-1:0]        afe_data
);

  // ============================================================
  // Helper functions

  // Transmit fields written for this direction
  function automatic logic dir_has_tx(input logic [1:0] d);
    dir_has_tx = (d != TARW_DIR_RX);  // R6 R12
  endfunction : dir_has_tx

  // Receive fields written for this direction
  function automatic logic dir_has_rx(input logic [1:0] d);
    dir_has_rx = (d != TARW_DIR_TX);  // R6 R12
  endfunction : dir_has_rx

  // First field pushed for a direction
  function automatic logic [1:0] first_field(input logic [1:0] d);
    if (dir_has_tx(d)) begin
      first_field = TARW_FLD_VOD;
    end else begin
      first_field = TARW_FLD_DCGAIN;
    end
  endfunction : first_field

  // Last field pushed for a direction
  function automatic logic [1:0] last_field(input logic [1:0] d);
    if (dir_has_rx(d)) begin
      last_field = TARW_FLD_EQCTRL;
    end else begin
      last_field = TARW_FLD_PREEMP;
    end
  endfunction : last_field

  // Zero-extended value of one field
  function automatic logic [`TARW_DATA_W-1:0] field_value(
    input tarw_setting_s s,
    input logic [1:0]    f
  );
    case (f)
      TARW_FLD_VOD:    field_value = {2'h0, s.vod};
      TARW_FLD_PREEMP: field_value = s.preemp;
      TARW_FLD_DCGAIN: field_value = {3'h0, s.dcgain};
      default:         field_value = {1'h0, s.eqctrl};
    endcase
  endfunction : field_value

  // Address used; a single channel has no address to honour
  function automatic logic [`TARW_CHAN_AW-1:0] eff_addr(
    input logic [`TARW_CHAN_AW-1:0] a
  );
    if (`TARW_CHAN_COUNT == 1) begin
      eff_addr = '0;  // R1
    end else begin
      eff_addr = a;   // R1
    end
  endfunction : eff_addr

  // ============================================================
  // State
  tarw_state_e                state_r;      // Controller state
  tarw_state_e                state_nxt;
  logic [`TARW_CNT_W-1:0]     cal_cnt_r;    // Calibration timer
  logic [`TARW_CNT_W-1:0]     cal_cnt_nxt;
  tarw_setting_s              cap_set_r;    // Captured settings
  tarw_setting_s              cap_set_nxt;
  logic [`TARW_CHAN_AW-1:0]   cap_addr_r;   // Captured channel
  logic [`TARW_CHAN_AW-1:0]   cap_addr_nxt;
  logic [1:0]                 cap_dir_r;    // Captured direction
  logic [1:0]                 cap_dir_nxt;
  logic [1:0]                 field_r;      // Field being pushed
  logic [1:0]                 field_nxt;
  logic [`TARW_DATA_W-1:0]    data_r;       // Value being pushed
  logic [`TARW_DATA_W-1:0]    data_nxt;

  // Memory port signals
  logic                       mem_wr_en;
  logic [`TARW_CHAN_AW-1:0]   mem_wr_addr;
  tarw_setting_s              mem_wr_data;
  logic [`TARW_CHAN_AW-1:0]   mem_rd_addr;
  tarw_setting_s              mem_rd_data;

  // Calibration end count, sized to the timer
  localparam logic [`TARW_CNT_W-1:0] CAL_LAST =
    `TARW_CNT_W'(`TARW_OFFCAL_CYCLES - 1);

  // ============================================================
  // Next-state logic
  always_comb begin
    state_nxt    = state_r;
    cal_cnt_nxt  = cal_cnt_r;
    cap_set_nxt  = cap_set_r;
    cap_addr_nxt = cap_addr_r;
    cap_dir_nxt  = cap_dir_r;
    field_nxt    = field_r;
    data_nxt     = data_r;
    case (state_r)
      // Power-up offset cancellation; also clears the store
      TARW_ST_CAL: begin
        cal_cnt_nxt = cal_cnt_r + `TARW_CNT_W'(1);
        if (cal_cnt_r == CAL_LAST) begin
          state_nxt = TARW_ST_IDLE;  // R14
        end
      end
      // Wait for a write; only the strobe leaves here
      TARW_ST_IDLE: begin
        if (write_strobe) begin  // R16
          cap_set_nxt  = setting_in;            // R15
          cap_addr_nxt = eff_addr(chan_addr);   // R15
          cap_dir_nxt  = dir_sel;               // R15
          field_nxt    = first_field(dir_sel);
          data_nxt     = field_value(setting_in, first_field(dir_sel));
          state_nxt    = TARW_ST_PUSH;          // R9 R14
        end
      end
      // One field per accepted handshake; strobes are not looked at
      TARW_ST_PUSH: begin
        if (afe_ready) begin
          if (field_r == last_field(cap_dir_r)) begin
            state_nxt = TARW_ST_COMMIT;
          end else begin
            field_nxt = field_r + 2'h1;
            data_nxt  = field_value(cap_set_r, field_r + 2'h1);
          end
        end
      end
      // Record the new settings, then release busy
      default: begin
        state_nxt = TARW_ST_IDLE;  // R9
      end
    endcase
  end

  // ============================================================
  // State registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r    <= TARW_ST_CAL;
      cal_cnt_r  <= '0;
      cap_set_r  <= `TARW_SET_RST;
      cap_addr_r <= '0;
      cap_dir_r  <= TARW_DIR_DUPLEX;
      field_r    <= TARW_FLD_VOD;
      data_r     <= '0;
    end else if (ce) begin
      state_r    <= state_nxt;
      cal_cnt_r  <= cal_cnt_nxt;
      cap_set_r  <= cap_set_nxt;
      cap_addr_r <= cap_addr_nxt;
      cap_dir_r  <= cap_dir_nxt;
      field_r    <= field_nxt;
      data_r     <= data_nxt;
    end
  end

  // ============================================================
  // Settings store port control
  always_comb begin
    mem_wr_en   = 1'b0;
    mem_wr_addr = cap_addr_r;
    mem_wr_data = mem_rd_data;
    // Readback follows the live address while idle
    if (state_r == TARW_ST_IDLE) begin
      mem_rd_addr = eff_addr(chan_addr);  // R1
    end else begin
      mem_rd_addr = cap_addr_r;
    end
    if (state_r == TARW_ST_CAL) begin
      // Walk every channel 25 times so readback is defined
      mem_wr_en   = 1'b1;
      mem_wr_addr = cal_cnt_r[`TARW_CHAN_AW-1:0];
      mem_wr_data = `TARW_SET_RST;
    end else if (state_r == TARW_ST_COMMIT) begin
      // Old word was read at least two cycles ago; keep untouched half
      mem_wr_en = 1'b1;
      if (dir_has_tx(cap_dir_r)) begin
        mem_wr_data.vod    = cap_set_r.vod;     // R6
        mem_wr_data.preemp = cap_set_r.preemp;  // R6
      end
      if (dir_has_rx(cap_dir_r)) begin
        mem_wr_data.dcgain = cap_set_r.dcgain;  // R12
        mem_wr_data.eqctrl = cap_set_r.eqctrl;  // R12
      end
    end
  end

  // Settings store with registered read
  tarw_chan_mem u_mem (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .wr_en    (mem_wr_en),
    .wr_addr  (mem_wr_addr),
    .wr_data  (mem_wr_data),
    .rd_addr  (mem_rd_addr),
    .rd_data  (mem_rd_data)
  );

  // ============================================================
  // Outputs
  assign busy        = (state_r != TARW_ST_IDLE);  // R9 R16
  assign afe_valid   = (state_r == TARW_ST_PUSH);
  assign afe_chan    = cap_addr_r;
  assign afe_field   = field_r;
  assign afe_data    = data_r;
  assign setting_out = mem_rd_data;  // R2 R3

endmodule : tarw_write_ctrl

/* File: tb/tarw_afe_model.sv */
// Channel side model accepting offered settings
`timescale 1ns/10ps
module tarw_afe_model (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic slow,      // High: accept one cycle in three
  input  wire logic afe_valid,
  output logic      afe_ready
);
  logic [1:0] cnt_r;   // Stall phase
  logic [1:0] cnt_nxt;
  // Free running phase, so stalls land at varied fields
  always_comb begin
    cnt_nxt = (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
  end
  always_ff @(posedge core_clk) begin
    if (srst) cnt_r <= 2'h0;
    else cnt_r <= cnt_nxt;
  end
  assign afe_ready = afe_valid && (!slow || cnt_r == 2'h2);
endmodule : tarw_afe_model

/* File: tb/tarw_write_ctrl_properties.sv */
// Checker of the analog reconfiguration write block
`timescale 1ns/10ps
`include "tarw_defs.svh"
module tarw_write_ctrl_properties
  import tarw_pkg::*;
(
  input wire logic                     core_clk,
  input wire logic                     srst,
  input wire logic                     ce,
  input wire tarw_setting_s            setting_in,
  input wire logic [`TARW_CHAN_AW-1:0] chan_addr,
  input wire logic [1:0]               dir_sel,
  input wire logic                     write_strobe,
  input wire logic                     busy,
  input wire tarw_setting_s            setting_out,
  input wire logic                     afe_valid,
  input wire logic                     afe_ready,
  input wire logic [`TARW_CHAN_AW-1:0] afe_chan,
  input wire logic [1:0]               afe_field,
  input wire logic [`TARW_DATA_W-1:0]  afe_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ====
  // Own copy of the taken request
  tarw_setting_s            set_r;
  logic [1:0]               dir_r;
  logic [`TARW_CHAN_AW-1:0] chan_r;
  logic [1:0]               first_f; // First field for direction
  logic [1:0]               last_f;  // Last field for direction
  logic [`TARW_DATA_W-1:0]  exp_d;   // Expected offered value
  wire take = ce && !busy && write_strobe;
  // Capture only when taken, so a late recapture shows
  always_ff @(posedge core_clk) begin
    if (take) begin
      set_r <= setting_in;
      dir_r <= dir_sel;
      chan_r <= chan_addr;
    end
  end
  // Code 00 counts as duplex
  always_comb begin
    first_f = (dir_r == TARW_DIR_RX) ? 2'h2 : 2'h0;
    last_f = (dir_r == TARW_DIR_TX) ? 2'h1 : 2'h3;
    case (afe_field)
      2'h0: exp_d = {2'h0, set_r.vod};
      2'h1: exp_d = set_r.preemp;
      2'h2: exp_d = {3'h0, set_r.dcgain};
      default: exp_d = {1'h0, set_r.eqctrl};
    endcase
  end
  sequence s_take; ce && !busy && write_strobe; endsequence
  sequence s_hs; ce && afe_valid && afe_ready; endsequence
  // ====
  // Properties
  a_take_busy: assert property (s_take |=> busy && afe_valid)
    else $error("no busy after strobe");
  a_busy_cause: assert property ($rose(busy) |-> $past(take))
    else $error("busy rose without request");
  a_offer_cause: assert property ($rose(afe_valid) |-> $past(take))
    else $error("offer without taken strobe");
  a_first_field: assert property ($rose(afe_valid) |->
    afe_field == first_f && afe_chan == chan_r)
    else $error("wrong first field or channel");
  a_field_data: assert property (afe_valid |-> afe_data == exp_d)
    else $error("offered value differs from taken");
  a_offer_hold: assert property (afe_valid && !(afe_ready && ce) |=>
    afe_valid && $stable(afe_field) && $stable(afe_data))
    else $error("offer changed before accept");
  a_field_next: assert property (s_hs ##0 afe_field != last_f |=>
    afe_valid && afe_field == $past(afe_field) + 2'h1)
    else $error("field order broken");
  a_last_field: assert property (s_hs ##0 afe_field == last_f |=>
    !afe_valid && busy)
    else $error("extra field after last");
  a_busy_drop: assert property ($fell(afe_valid) && ce |=> !busy)
    else $error("busy stuck after transfer");
  a_valid_busy: assert property (afe_valid |-> busy)
    else $error("offer while idle");
endmodule : tarw_write_ctrl_properties

/* File: tb/tarw_write_ctrl_test.sv */
// Self-checking bench of the analog reconfiguration write block
`timescale 1ns/10ps
`include "tarw_defs.svh"
module tarw_write_ctrl_test
  import tarw_pkg::*;
;
  logic                     core_clk = 1'b0;
  logic                     srst = 1'b1;
  logic                     ce = 1'b1;
  logic                     write_strobe = 1'b0;
  logic                     slow = 1'b0;
  logic [1:0]               dir_sel = 2'h3;
  logic [`TARW_CHAN_AW-1:0] chan_addr = 2'h0;
  tarw_setting_s            setting_in = 14'h0000;
  tarw_setting_s            setting_out;
  logic                     busy, afe_valid, afe_ready;
  logic [`TARW_CHAN_AW-1:0] afe_chan;
  logic [1:0]               afe_field;
  logic [`TARW_DATA_W-1:0]  afe_data;
  tarw_setting_s            exp_mem [4]; // Expected channel store
  int err_count = 0, n_compared = 0, hs_cnt = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  tarw_write_ctrl tarw_write_ctrl_inst (.core_clk(core_clk), .srst(srst),
    .ce(ce), .setting_in(setting_in), .chan_addr(chan_addr),
    .dir_sel(dir_sel), .write_strobe(write_strobe), .busy(busy),
    .setting_out(setting_out), .afe_valid(afe_valid),
    .afe_ready(afe_ready), .afe_chan(afe_chan), .afe_field(afe_field),
    .afe_data(afe_data));
  tarw_afe_model tarw_afe_model_inst (.core_clk(core_clk), .srst(srst),
    .slow(slow), .afe_valid(afe_valid), .afe_ready(afe_ready));
  // Count accepted fields; cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (ce && afe_valid && afe_ready) hs_cnt <= hs_cnt + 1;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic cmp_num(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_num
  task automatic cmp_set(input tarw_setting_s got, input tarw_setting_s exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_set
  // Bounded wait for idle
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    cmp_num(busy, 32'h0);
  endtask : wait_idle
  // Calibration holds busy about 100 cycles
  task automatic t_cal();
    int n;
    n = 0;
    while (busy === 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    cmp_num(32'(n >= 100 && n <= 101), 32'h1);
  endtask : t_cal
  // One write, inputs scrambled after capture, strobe again while busy
  task automatic t_write(input logic [1:0] dir, input logic [1:0] ch,
                         input tarw_setting_s s, input logic sl);
    tarw_setting_s e;
    int            hs0; // Handshake count before this write
    wait_idle();
    slow = sl;
    setting_in = s;
    chan_addr = ch;
    dir_sel = dir;
    write_strobe = 1'b1;
    hs0 = hs_cnt;
    @(negedge core_clk);
    write_strobe = 1'b0;
    setting_in = ~s;
    dir_sel = ~dir;
    chan_addr = ch + 2'h1;
    @(negedge core_clk);
    write_strobe = 1'b1;
    @(negedge core_clk);
    write_strobe = 1'b0;
    wait_idle();
    e = exp_mem[ch];
    if (dir != TARW_DIR_RX) e[13:6] = s[13:6];
    if (dir != TARW_DIR_TX) e[5:0] = s[5:0];
    exp_mem[ch] = e;
    cmp_num(hs_cnt - hs0, (dir == 2'h1 || dir == 2'h2) ? 2 : 4);
    chan_addr = ch;
    repeat (2) @(negedge core_clk);
    cmp_set(setting_out, e);
  endtask : t_write
  // Strobe with clock enable low is not taken
  task automatic t_freeze();
    wait_idle();
    ce = 1'b0;
    write_strobe = 1'b1;
    repeat (3) @(negedge core_clk);
    write_strobe = 1'b0;
    ce = 1'b1;
    @(negedge core_clk);
    cmp_num(busy, 32'h0);
  endtask : t_freeze
  task automatic final_report();
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  initial begin
    exp_mem = '{default: 14'h0000};
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    t_cal();
    cmp_num($bits(setting_in.vod), 32'h3);
    cmp_num($bits(setting_out.preemp), 32'h5);
    cmp_num($bits(setting_in.dcgain), 32'h2);
    cmp_num($bits(setting_out.eqctrl), 32'h4);
    for (int i = 0; i < 8; i++) begin
      t_write(i[1:0], {i[0], i[2]},
              tarw_setting_s'(14'h2A5C ^ 14'(i * 14'h0F31)), i[2]);
    end
    t_freeze();
    final_report();
  end
endmodule : tarw_write_ctrl_test
bind tarw_write_ctrl tarw_write_ctrl_properties tarw_props_inst (
  .core_clk(core_clk), .srst(srst), .ce(ce), .setting_in(setting_in),
  .chan_addr(chan_addr), .dir_sel(dir_sel), .write_strobe(write_strobe),
  .busy(busy), .setting_out(setting_out), .afe_valid(afe_valid),
  .afe_ready(afe_ready), .afe_chan(afe_chan), .afe_field(afe_field),
  .afe_data(afe_data));
